// ===== hw/buck_ctrl_map.svh
// Constants of the buck converter control: field positions, reset values, timing counts.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef BUCK_CTRL_MAP_SVH
`define BUCK_CTRL_MAP_SVH

// ==================================================
// Setpoint word fields
`define SP_VOUT_LSB 0
`define SP_VOUT_MSB 6
`define SP_ENABLE_BIT 7
`define SP_VOUT_W 7
// ==================================================
// Voltage code scale, microvolts
`define VOUT_BASE_UV 600000
`define VOUT_STEP_UV 6250
`define VOUT_MAX_UV 1400000
`define VOUT_CODE_MAX 7'h7F
// ==================================================
// Peak current limits, milliamps, by code
`define ILIM_CODE0_MA 16'h1450
`define ILIM_CODE1_MA 16'h16A8
`define ILIM_CODE2_MA 16'h1838
`define ILIM_CODE3_MA 16'h1A90
// ==================================================
// Reset values of the settings (factory defaults)
`define RST_SETPOINT 8'h00
`define RST_ILIM_SEL 2'h0
// ==================================================
// Timing: oscillator 2.74 MHz against 10 MHz clock, kHz units
`define CLK_KHZ 10000
`define SW_KHZ 2740
// Least off time after a peak-limit trip, ns
`define TRIP_OFF_NS 100
`define CLK_NS 100

`endif

// ===== hw/buck_ctrl_pkg.sv
// Types of the buck converter control block.
// Assumes the map header supplies all numbers.
package buck_ctrl_pkg;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_PWM = 4'b0010,
    ST_PFM = 4'b0100,
    ST_TSD = 4'b1000
  } conv_state_t;

  // One setpoint register: enable, 7-bit voltage code
  typedef struct packed {
    logic enable;
    logic [6:0] vout_code;
  } setpoint_t;

  // Analog comparator indications
  typedef struct packed {
    logic over_temp;
    logic cooled;
    logic undervoltage;
    logic peak_trip;
    logic discontinuous;
  } sense_t;

  // Selected target handed to the analog loop
  typedef struct packed {
    logic [6:0] vout_code;
    logic [20:0] vout_uv;
    logic [15:0] ilim_ma;
    logic force_pwm;
  } target_t;

endpackage

// ===== hw/buck_sw_clock.sv
// Fractional divider making the 2.74 MHz switching tick from the system clock.
// Assumes a single clock domain and synchronous active-low reset.
`timescale 1ns/10ps
`include "buck_ctrl_map.svh"
module buck_sw_clock #(
  parameter int CLK_KHZ = `CLK_KHZ,
  parameter int SW_KHZ = `SW_KHZ
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Tick out, one cycle per switching period
  output logic tick_o
);
  if (SW_KHZ <= 0 || SW_KHZ >= CLK_KHZ) begin : g_bad_rate
    $error("Switching rate must be below the clock rate");
  end
  // The accumulator holds values below CLK_KHZ in 16 bits
  if (CLK_KHZ > 65535) begin : g_bad_clock
    $error("Clock rate too high for the accumulator");
  end

  logic [15:0] acc;
  logic [15:0] next_acc;
  logic next_tick;
  logic [16:0] sum;

  // Phase accumulator keeps the mean rate exact though each period jitters by a cycle
  always_comb begin
    sum = {1'b0, acc} + 17'(SW_KHZ);
    if (sum >= 17'(CLK_KHZ)) begin
      next_acc = 16'(sum - 17'(CLK_KHZ));
      next_tick = 1'b1;
    end else begin
      next_acc = sum[15:0];
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      acc <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      acc <= next_acc;
      tick_o <= next_tick;
    end
  end
endmodule // buck_sw_clock

// ===== hw/buck_converter_control.sv
// Digital control of a step-down converter: setpoint choice, mode, limits, thermal shutdown.
// Assumes settings arrive already registered from the host-side register file.
// Assumes comparator inputs are glitch-free digital levels, asynchronous to the clock.
`timescale 1ns/10ps
`include "buck_ctrl_map.svh"
module buck_converter_control #(
  parameter int CLK_KHZ = `CLK_KHZ,
  parameter int SW_KHZ = `SW_KHZ,
  parameter int TRIP_OFF_NS = `TRIP_OFF_NS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Device pins
  input wire logic enable_pin_i,
  input wire logic voltage_select_pin_i,
  // Settings from the register file
  input wire buck_ctrl_pkg::setpoint_t setpoint_reg_0_i,
  input wire buck_ctrl_pkg::setpoint_t setpoint_reg_1_i,
  input wire logic force_pwm_0_i,
  input wire logic force_pwm_1_i,
  input wire logic voltage_select_pin_gate_i,
  input wire logic [1:0] peak_current_limit_sel_i,
  input wire logic restart_after_thermal_i,
  input wire logic thermal_irq_ack_i,
  // Analog comparators
  input wire buck_ctrl_pkg::sense_t sense_i,
  // Outputs toward the analog loop and host
  output buck_ctrl_pkg::target_t target_o,
  output logic output_on_o,
  output logic high_side_on_o,
  output logic pfm_active_o,
  output logic thermal_shutdown_o,
  output logic thermal_irq_o
);
  // Least off time in cycles, rounded up so a trip never gets a shorter pause
  localparam longint TRIP_OFF_PROD = longint'(TRIP_OFF_NS) * longint'(CLK_KHZ);
  localparam int TRIP_OFF_CYC_RAW = int'((TRIP_OFF_PROD + 999999) / 1000000);
  localparam int TRIP_OFF_CYC = (TRIP_OFF_CYC_RAW < 1) ? 1 : TRIP_OFF_CYC_RAW;

  // ==================================================
  // Parameter checks
  if (TRIP_OFF_NS < 0 || TRIP_OFF_CYC > 255) begin : g_bad_trip
    $error("Trip off time out of range for its counter");
  end
  if (SW_KHZ <= 0 || SW_KHZ >= CLK_KHZ) begin : g_bad_rate
    $error("Switching rate must be below the clock rate");
  end
  if (CLK_KHZ > 65535) begin : g_bad_clock
    $error("Clock rate too high for the switching accumulator");
  end
  if ($bits(buck_ctrl_pkg::sense_t) != 5) begin : g_bad_sense
    $error("Synchroniser map expects five comparator bits");
  end

  // ==================================================
  // Input synchronisers
  // two-stage synchronisers
  // Costs two cycles on every pin and comparator; shorter pulses may be missed
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  assign raw_in = {enable_pin_i, voltage_select_pin_i, sense_i};

  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          sync_a[i] <= 1'b0;
          sync_b[i] <= 1'b0;
        end else begin
          sync_a[i] <= raw_in[i];
          sync_b[i] <= sync_a[i];
        end
      end
    end
  endgenerate

  logic en_s;
  logic voltage_select_pin_s;
  buck_ctrl_pkg::sense_t sense_s;
  assign en_s = sync_b[6];
  assign voltage_select_pin_s = sync_b[5];
  assign sense_s = sync_b[4:0];

  // ==================================================
  // Switching tick
  // lockout stops the oscillator too, so it restarts in a known phase
  logic core_nrst;
  assign core_nrst = nrst_i && !sense_s.undervoltage;
  logic sw_tick;
  buck_sw_clock #(
    .CLK_KHZ(CLK_KHZ),
    .SW_KHZ(SW_KHZ)
  ) u_sw_clock (
    .clock_i(clock_i),
    .nrst_i(core_nrst),
    .tick_o(sw_tick)
  );

  // ==================================================
  // Setpoint selection and target decode
  logic use_sp0;
  buck_ctrl_pkg::setpoint_t active_sp;
  logic active_force;
  buck_ctrl_pkg::target_t next_target;
  logic [20:0] vout_uv_calc;

  always_comb begin
    // setpoint choice; gate low masks pin
    use_sp0 = voltage_select_pin_gate_i && !voltage_select_pin_s;
    active_sp = use_sp0 ? setpoint_reg_0_i : setpoint_reg_1_i;
    active_force = use_sp0 ? force_pwm_0_i : force_pwm_1_i;
    // code to microvolts, clamped at the top of range
    vout_uv_calc = 21'(`VOUT_BASE_UV) + 21'(active_sp.vout_code) * 21'(`VOUT_STEP_UV);
    if (vout_uv_calc > 21'(`VOUT_MAX_UV)) begin
      vout_uv_calc = 21'(`VOUT_MAX_UV);
    end
    next_target.vout_code = active_sp.vout_code;
    next_target.vout_uv = vout_uv_calc;
    next_target.force_pwm = active_force;
    case (peak_current_limit_sel_i)
      2'h0: next_target.ilim_ma = `ILIM_CODE0_MA;
      2'h1: next_target.ilim_ma = `ILIM_CODE1_MA;
      2'h2: next_target.ilim_ma = `ILIM_CODE2_MA;
      default: next_target.ilim_ma = `ILIM_CODE3_MA;
    endcase
  end

  always_ff @(posedge clock_i) begin
    // undervoltage acts as reset too; target cleared to all zeros at reset
    if (!nrst_i || sense_s.undervoltage) begin
      target_o <= '0;
    end else begin
      target_o <= next_target;
    end
  end

  // ==================================================
  // Converter state machine
  buck_ctrl_pkg::conv_state_t state;
  buck_ctrl_pkg::conv_state_t next_state;
  logic en_prev;
  logic next_en_prev;
  logic en_rise;
  logic armed;
  logic next_armed;
  logic run_req;
  logic irq;
  logic next_irq;
  logic tsd_entry;

  always_comb begin
    next_en_prev = en_s;
    en_rise = en_s && !en_prev;
    next_armed = armed;
    run_req = en_s && active_sp.enable && armed;
    next_state = state;
    tsd_entry = 1'b0;
    if (en_rise) begin
      next_armed = 1'b1;
    end
    case (state)
      buck_ctrl_pkg::ST_OFF: begin
        if (run_req || (en_rise && active_sp.enable)) begin
          next_state = buck_ctrl_pkg::ST_PWM;
        end
      end
      buck_ctrl_pkg::ST_PWM, buck_ctrl_pkg::ST_PFM: begin
        // protection armed only with output on; enter on over-temp
        if (sense_s.over_temp) begin
          next_state = buck_ctrl_pkg::ST_TSD;
          tsd_entry = 1'b1;
          // without restart, wait for an enable toggle
          if (!restart_after_thermal_i) begin
            next_armed = 1'b0;
          end
        end else if (!run_req) begin
          next_state = buck_ctrl_pkg::ST_OFF;
        end else if (active_force) begin
          next_state = buck_ctrl_pkg::ST_PWM;
        end else if (state == buck_ctrl_pkg::ST_PWM && sense_s.discontinuous) begin
          next_state = buck_ctrl_pkg::ST_PFM;
        end else if (state == buck_ctrl_pkg::ST_PFM && !sense_s.discontinuous) begin
          next_state = buck_ctrl_pkg::ST_PWM;
        end
      end
      buck_ctrl_pkg::ST_TSD: begin
        // leave only once cooled; re-arm keeps settings untouched
        if (sense_s.cooled && !sense_s.over_temp) begin
          next_state = buck_ctrl_pkg::ST_OFF;
        end
      end
      default: next_state = buck_ctrl_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clock_i) begin
    // undervoltage holds the controller in reset
    if (!nrst_i || sense_s.undervoltage) begin
      state <= buck_ctrl_pkg::ST_OFF;
      en_prev <= 1'b0;
      armed <= 1'b0;
    end else begin
      state <= next_state;
      en_prev <= next_en_prev;
      armed <= next_armed;
    end
  end

  // ==================================================
  // Thermal interrupt
  always_comb begin
    // sticky interrupt, a new event wins over the acknowledge
    next_irq = irq;
    if (thermal_irq_ack_i) begin
      next_irq = 1'b0;
    end
    if (tsd_entry) begin
      next_irq = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!core_nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ==================================================
  // Pulse generation with peak limiting
  logic [7:0] blank_cnt;
  logic [7:0] next_blank_cnt;
  logic next_hs;
  logic next_on;
  logic switching;
  logic next_pfm;
  logic next_tsd_flag;

  always_comb begin
    switching = (state == buck_ctrl_pkg::ST_PWM) || (state == buck_ctrl_pkg::ST_PFM);
    next_blank_cnt = (blank_cnt != 8'h00) ? blank_cnt - 8'h01 : 8'h00;
    next_hs = high_side_on_o;
    // output off outside run states, including shutdown
    next_on = (next_state == buck_ctrl_pkg::ST_PWM) || (next_state == buck_ctrl_pkg::ST_PFM);
    next_pfm = (next_state == buck_ctrl_pkg::ST_PFM);
    next_tsd_flag = (next_state == buck_ctrl_pkg::ST_TSD);
    if (!switching || !next_on) begin
      next_hs = 1'b0;
    // trip ends the pulse and holds off a least time
    end else if (sense_s.peak_trip) begin
      next_hs = 1'b0;
      next_blank_cnt = 8'(TRIP_OFF_CYC);
    // each tick with the trip hold-off over starts a pulse; duty is set by the analog loop via the trip
    end else if (sw_tick && blank_cnt == 8'h00) begin
      next_hs = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i || sense_s.undervoltage) begin
      blank_cnt <= 8'h00;
      high_side_on_o <= 1'b0;
      output_on_o <= 1'b0;
      pfm_active_o <= 1'b0;
      thermal_shutdown_o <= 1'b0;
      thermal_irq_o <= 1'b0;
    end else begin
      blank_cnt <= next_blank_cnt;
      high_side_on_o <= next_hs;
      output_on_o <= next_on;
      pfm_active_o <= next_pfm;
      thermal_shutdown_o <= next_tsd_flag;
      thermal_irq_o <= next_irq;
    end
  end
endmodule // buck_converter_control

// ===== tb/buck_control_sva.sv
// Checker of the buck control outputs against their causes.
// Assumes pins and comparators pass two sync stages in the block.
`timescale 1ns/10ps
module buck_control_sva (
  // Clock and reset
  input logic clock_i,
  input logic nrst_i,
  // Pins, settings, comparators
  input logic voltage_select_pin_i,
  input logic voltage_select_pin_gate_i,
  input buck_ctrl_pkg::setpoint_t setpoint_reg_0_i,
  input logic [1:0] peak_current_limit_sel_i,
  input logic restart_after_thermal_i,
  input buck_ctrl_pkg::sense_t sense_i,
  // Outputs
  input buck_ctrl_pkg::target_t target_o,
  input logic output_on_o,
  input logic high_side_on_o,
  input logic thermal_shutdown_o,
  input logic thermal_irq_o
);
  localparam logic [15:0] LIM [4] = '{16'h1450, 16'h16A8, 16'h1838, 16'h1A90};
  logic [3:0] uv_h;
  // ====
  // Lockout acts late through the sync chain, so checks pause a while
  always_ff @(posedge clock_i) begin
    uv_h <= {uv_h[2:0], sense_i.undervoltage};
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i || sense_i.undervoltage || (|uv_h));
  sequence sel0_s;
    (voltage_select_pin_gate_i && !voltage_select_pin_i) [*4];
  endsequence
  sequence off8_s;
    !output_on_o [*8];
  endsequence
  sel_zero_a: assert property (sel0_s |=>
    target_o.vout_code == $past(setpoint_reg_0_i.vout_code)) else $error("setpoint 0 unused");
  limit_code_a: assert property (1 |=>
    target_o.ilim_ma == LIM[$past(peak_current_limit_sel_i)]) else $error("bad limit");
  trip_cut_a: assert property (sense_i.peak_trip |-> ##3 !high_side_on_o)
    else $error("trip ignored");
  uv_reset_a: assert property (disable iff (!nrst_i)
    sense_i.undervoltage [*3] |=> target_o == '0 && !output_on_o && !thermal_irq_o)
    else $error("lockout ignored");
  tsd_off_a: assert property (thermal_shutdown_o |-> !output_on_o)
    else $error("on in shutdown");
  tsd_armed_a: assert property ($rose(thermal_shutdown_o) |-> $past(output_on_o))
    else $error("shutdown while off");
  stay_off_a: assert property (
    $fell(thermal_shutdown_o) && !restart_after_thermal_i |-> off8_s) else $error("restarted");
  restart_after_thermal_run_a: assert property (
    $fell(thermal_shutdown_o) && restart_after_thermal_i |-> ##[1:2] output_on_o)
    else $error("no restart");
  tsd_irq_a: assert property ($rose(thermal_shutdown_o) |-> thermal_irq_o)
    else $error("no interrupt");
  tsd_hyst_a: assert property (
    (thermal_shutdown_o && !sense_i.cooled) [*3] |=> thermal_shutdown_o) else $error("left early");
endmodule // buck_control_sva
bind buck_converter_control buck_control_sva chk (.clock_i, .nrst_i, .voltage_select_pin_i,
  .voltage_select_pin_gate_i, .setpoint_reg_0_i, .peak_current_limit_sel_i, .restart_after_thermal_i,
  .sense_i, .target_o, .output_on_o, .high_side_on_o, .thermal_shutdown_o, .thermal_irq_o);

// ===== tb/buck_host_model.sv
// Host model: answers the thermal interrupt with a one-cycle acknowledge.
// Assumes the block's clock and reset; the delay makes it prompt or slow.
`timescale 1ns/10ps
module buck_host_model (
  // Clock and reset
  input logic clock_i,
  input logic nrst_i,
  // Interrupt service
  input logic irq_i,
  input logic [3:0] ack_delay_i,
  output logic ack_o
);
  logic [3:0] wait_cnt = 4'h0;
  logic ack_q = 1'b0;
  assign ack_o = ack_q;
  always @(posedge clock_i) begin
    if (!nrst_i || !irq_i || ack_q) begin
      wait_cnt <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      ack_q <= wait_cnt == ack_delay_i;
    end
  end
endmodule // buck_host_model

// ===== tb/buck_converter_control_bench.sv
// Bench of the buck control: drives pins, settings, comparators.
// Assumes package, block, host model and checker compiled first.
`timescale 1ns/10ps
module buck_converter_control_bench;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic enable_pin_i = 1'b0;
  logic voltage_select_pin_i = 1'b0;
  buck_ctrl_pkg::setpoint_t setpoint_reg_0_i = 8'h80;
  buck_ctrl_pkg::setpoint_t setpoint_reg_1_i = 8'hFF;
  logic force_pwm_0_i = 1'b0;
  logic force_pwm_1_i = 1'b0;
  logic voltage_select_pin_gate_i = 1'b0;
  logic [1:0] peak_current_limit_sel_i = 2'h0;
  logic restart_after_thermal_i = 1'b0;
  logic thermal_irq_ack_i;
  buck_ctrl_pkg::sense_t sense_i = '0;
  buck_ctrl_pkg::target_t target_o;
  logic output_on_o;
  logic high_side_on_o;
  logic pfm_active_o;
  logic thermal_shutdown_o;
  logic thermal_irq_o;
  logic [3:0] ack_delay = 4'h0;
  logic [6:0] code;
  int n_fail = 0;
  int checks_done = 0;
  int i;
  localparam logic [15:0] LIM [4] = '{16'h1450, 16'h16A8, 16'h1838, 16'h1A90};
  buck_converter_control dut (.clock_i, .nrst_i, .enable_pin_i, .voltage_select_pin_i,
    .setpoint_reg_0_i, .setpoint_reg_1_i, .force_pwm_0_i, .force_pwm_1_i, .voltage_select_pin_gate_i,
    .peak_current_limit_sel_i, .restart_after_thermal_i, .thermal_irq_ack_i, .sense_i,
    .target_o, .output_on_o, .high_side_on_o, .pfm_active_o, .thermal_shutdown_o,
    .thermal_irq_o);
  buck_host_model host (.clock_i, .nrst_i, .irq_i(thermal_irq_o), .ack_delay_i(ack_delay),
    .ack_o(thermal_irq_ack_i));
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    cyc(12);
    nrst_i = 1'b1;
    cyc(2);
    for (i = 0; i < 4; i++) begin
      voltage_select_pin_gate_i = i[1];
      voltage_select_pin_i = i[0];
      cyc(4);
      code = (i == 2) ? 7'h00 : 7'h7F;
      check("vout_code", target_o.vout_code, code);
      check("vout_uv", target_o.vout_uv, 21'h927C0 + 21'h186A * code);
    end
    for (i = 0; i < 4; i++) begin
      peak_current_limit_sel_i = i[1:0];
      cyc(2);
      check("ilim", target_o.ilim_ma, LIM[i]);
    end
    voltage_select_pin_gate_i = 1'b0;
    enable_pin_i = 1'b1;
    cyc(4);
    check("run", output_on_o, 1'b1);
    for (i = 0; i < 40 && high_side_on_o !== 1'b1; i++) begin
      cyc(1);
    end
    check("tick", i < 40, 1'b1);
    if (i == 40) finish_test();
    sense_i.peak_trip = 1'b1;
    cyc(3);
    check("trip", high_side_on_o, 1'b0);
    sense_i.peak_trip = 1'b0;
    sense_i.discontinuous = 1'b1;
    cyc(5);
    check("pfm", pfm_active_o, 1'b1);
    force_pwm_1_i = 1'b1;
    cyc(2);
    check("forced", pfm_active_o, 1'b0);
    check("force_bit", target_o.force_pwm, 1'b1);
    force_pwm_1_i = 1'b0;
    sense_i.discontinuous = 1'b0;
    cyc(5);
    check("ccm", pfm_active_o, 1'b0);
    sense_i.over_temp = 1'b1;
    cyc(3);
    check("tsd", thermal_shutdown_o, 1'b1);
    check("tsd_on", output_on_o, 1'b0);
    check("irq", thermal_irq_o, 1'b1);
    sense_i.over_temp = 1'b0;
    cyc(4);
    check("tsd_hold", thermal_shutdown_o, 1'b1);
    sense_i.cooled = 1'b1;
    cyc(10);
    sense_i.cooled = 1'b0;
    check("tsd_end", thermal_shutdown_o, 1'b0);
    check("stay_off", output_on_o, 1'b0);
    check("irq_ack", thermal_irq_o, 1'b0);
    enable_pin_i = 1'b0;
    cyc(4);
    enable_pin_i = 1'b1;
    restart_after_thermal_i = 1'b1;
    ack_delay = 4'h9;
    cyc(4);
    check("rerun", output_on_o, 1'b1);
    sense_i.over_temp = 1'b1;
    cyc(3);
    sense_i.over_temp = 1'b0;
    sense_i.cooled = 1'b1;
    cyc(5);
    sense_i.cooled = 1'b0;
    check("restart_after_thermal", output_on_o, 1'b1);
    check("kept", target_o.vout_code, 7'h7F);
    check("irq_slow", thermal_irq_o, 1'b1);
    enable_pin_i = 1'b0;
    cyc(4);
    sense_i.over_temp = 1'b1;
    cyc(5);
    check("unarmed", thermal_shutdown_o, 1'b0);
    sense_i.over_temp = 1'b0;
    enable_pin_i = 1'b1;
    sense_i.undervoltage = 1'b1;
    cyc(4);
    check("uv_on", output_on_o, 1'b0);
    check("uv_tgt", target_o, 64'h0);
    finish_test();
  end
endmodule // buck_converter_control_bench
